// ---- rtl/pec_top.v ----
/*
 * performance event counters: four channels, window control, apb
 * register file and overflow/close/error interrupt.
 * assumes cpu event strobes, run and break inputs synchronous to sys_clk_i;
 * ce_i low models the cpu clock halted in sleep.
 */
`timescale 1ns/1ps
`include "pec_map.vh"
module pec_top #(
  parameter NCH = 4,
  parameter HAS_DSP = 1,
  parameter HAS_MMU = 1,
  parameter HAS_XY = 1,
  parameter HAS_U = 1
) (
  input wire sys_clk_i,
  input wire reset_n_i,
  input wire ce_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] pwdata_i,
  output reg [31:0] prdata_o,
  output reg pready_o,
  output reg pslverr_o,
  input wire run_start_i,
  input wire any_break_i,
  input wire brk1_i,
  input wire brk2_i,
  input wire brk_halt_req_i,
  input wire tick_i,
  input wire state_i,
  input wire branch_i,
  input wire insn_i,
  input wire dsp_insn_i,
  input wire exc_i,
  input wire int_i,
  input wire icache_miss_i,
  input wire dcache_miss_i,
  input wire stall_i,
  input wire dtlb_miss_i,
  input wire itlb_miss_i,
  input wire xy_stall_i,
  input wire u_stall_i,
  input wire acc_cyc_i,
  input wire acc_start_i,
  input wire area_cacheable_i,
  output reg cpu_halt_o,
  output reg window_open_o,
  output reg irq_o
);
  reg [1:0] mode;
  reg [`PEC_SEL_W*NCH-1:0] sel;
  reg [`PEC_IRQ_W-1:0] irq_stat;
  reg [`PEC_IRQ_W-1:0] irq_mask;
  reg setup_err;
  reg init_req;
  reg ovf_q;
  wire [NCH-1:0] ovf;
  wire [32*NCH-1:0] counts;
  wire [18:0] ev;
  wire win_open;
  wire win_close;
  wire any_sel;
  wire arm_ok;
  wire wr;
  wire rd;
  wire is_win_mode;
  wire [NCH-1:0] ovf_rise;
  reg [NCH-1:0] ovf_prev;
  reg [`PEC_IRQ_W-1:0] next_irq_stat;
  reg [31:0] next_rdata;
  reg next_err;
  integer k;

  // cacheable class is the area's, not what the tlb did with it
  assign ev[`PEC_EV_OFF] = 1'b0;
  assign ev[`PEC_EV_TIME] = 1'b1;
  assign ev[`PEC_EV_STATES] = state_i;
  assign ev[`PEC_EV_BRANCH] = branch_i;
  assign ev[`PEC_EV_INSN] = insn_i;
  assign ev[`PEC_EV_DSP] = dsp_insn_i;
  assign ev[`PEC_EV_EXC] = exc_i;
  assign ev[`PEC_EV_INT] = int_i;
  assign ev[`PEC_EV_ICMISS] = icache_miss_i;
  assign ev[`PEC_EV_DCMISS] = dcache_miss_i;
  assign ev[`PEC_EV_STALL] = stall_i;
  assign ev[`PEC_EV_DTLB] = dtlb_miss_i;
  assign ev[`PEC_EV_ITLB] = itlb_miss_i;
  assign ev[`PEC_EV_XYSTALL] = xy_stall_i;
  assign ev[`PEC_EV_USTALL] = u_stall_i;
  assign ev[`PEC_EV_CC_CYC] = acc_cyc_i & area_cacheable_i; // RULE9
  assign ev[`PEC_EV_NC_CYC] = acc_cyc_i & ~area_cacheable_i;
  assign ev[`PEC_EV_CC_CNT] = acc_start_i & area_cacheable_i;
  assign ev[`PEC_EV_NC_CNT] = acc_start_i & ~area_cacheable_i;

  assign is_win_mode = (mode == `PEC_MODE_1TO2) ||
    (mode == `PEC_MODE_2TO1);
  assign any_sel = |sel;
  // an empty window setup never arms
  assign arm_ok = !(is_win_mode && !any_sel); // RULE15

  pec_window u_win (
    .sys_clk_i(sys_clk_i),
    .reset_n_i(reset_n_i),
    .ce_i(ce_i),
    .mode_i(mode),
    .arm_ok_i(arm_ok),
    .run_start_i(run_start_i),
    .any_break_i(any_break_i),
    .brk1_i(brk1_i),
    .brk2_i(brk2_i),
    .open_o(win_open),
    .close_o(win_close)
  );

  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : ch
      pec_counter #(
        .WIDTH(32),
        .HAS_DSP(HAS_DSP),
        .HAS_MMU(HAS_MMU),
        .HAS_XY(HAS_XY),
        .HAS_U(HAS_U)
      ) u_cnt (
        .sys_clk_i(sys_clk_i),
        .reset_n_i(reset_n_i),
        .ce_i(ce_i),
        .count_en_i(win_open), // RULE5
        .init_i(init_req),
        .sel_i(sel[`PEC_SEL_W*g +: `PEC_SEL_W]),
        .ev_i(ev),
        .count_o(counts[32*g +: 32]),
        .ovf_o(ovf[g])
      );
    end
  endgenerate

  assign wr = psel_i & penable_i & pwrite_i & pready_o;
  assign rd = psel_i & ~penable_i & ~pwrite_i;
  assign ovf_rise = ovf & ~ovf_prev;

  always @* begin
    next_err = 1'b0;
    next_rdata = 32'h0000_0000;
    case (paddr_i)
      `PEC_OFF_CTRL: next_rdata = {30'h0, mode};
      `PEC_OFF_STAT: next_rdata = {{(32-`PEC_STAT_OVF_LO-NCH){1'b0}}, ovf,
        2'h0, setup_err, win_open};
      `PEC_OFF_IRQ_STAT: next_rdata = {{(32-`PEC_IRQ_W){1'b0}}, irq_stat};
      `PEC_OFF_IRQ_MASK: next_rdata = {{(32-`PEC_IRQ_W){1'b0}}, irq_mask};
      `PEC_OFF_SEL: next_rdata = {{(32-`PEC_SEL_W*NCH){1'b0}}, sel};
      default: begin
        if (paddr_i[11:4] == `PEC_OFF_CNT0 >> 4 &&
            paddr_i[3:2] < NCH && paddr_i[1:0] == 2'h0) begin
          next_rdata = counts[32*paddr_i[3:2] +: 32]; // RULE11
        end else begin
          next_err = 1'b1;
        end
      end
    endcase
    // set wins over the write-one clear
    next_irq_stat = irq_stat;
    if (wr && paddr_i == `PEC_OFF_IRQ_STAT) begin
      next_irq_stat = irq_stat & ~pwdata_i[`PEC_IRQ_W-1:0];
    end
    for (k = 0; k < NCH; k = k + 1) begin
      if (ovf_rise[k]) begin
        next_irq_stat[k] = 1'b1;
      end
    end
    if (win_close) begin
      next_irq_stat[`PEC_IRQ_CLOSE] = 1'b1;
    end
    if (wr && paddr_i == `PEC_OFF_CTRL && !any_sel &&
        (pwdata_i[1:0] == `PEC_MODE_1TO2 ||
        pwdata_i[1:0] == `PEC_MODE_2TO1)) begin
      next_irq_stat[`PEC_IRQ_ERR] = 1'b1;
    end
  end

  always @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      mode <= `PEC_MODE_RUN;
      sel <= {(`PEC_SEL_W*NCH){1'b0}};
      irq_stat <= {`PEC_IRQ_W{1'b0}};
      irq_mask <= {`PEC_IRQ_W{1'b0}};
      setup_err <= 1'b0;
      init_req <= 1'b0;
      ovf_prev <= {NCH{1'b0}};
      prdata_o <= 32'h0000_0000;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      cpu_halt_o <= 1'b0;
      window_open_o <= 1'b0;
      irq_o <= 1'b0;
    end else if (ce_i) begin
      // no wait state: setup cycle decodes, access answers
      pready_o <= psel_i & ~penable_i;
      pslverr_o <= psel_i & ~penable_i & next_err;
      // writes and refused accesses return zero read data
      if (psel_i && !penable_i) begin
        prdata_o <= rd ? next_rdata : 32'h0000_0000;
      end
      if (init_req) begin
        init_req <= 1'b0;
      end
      if (wr && !next_err) begin
        case (paddr_i)
          `PEC_OFF_CTRL: begin
            if (pwdata_i[`PEC_CTRL_INIT]) begin
              init_req <= 1'b1; // RULE13
            end
            if (is_win_mode ? 1'b1 : 1'b1) begin
              if (!any_sel && (pwdata_i[1:0] == `PEC_MODE_1TO2 ||
                  pwdata_i[1:0] == `PEC_MODE_2TO1)) begin
                setup_err <= 1'b1; // RULE15
              end else begin
                mode <= pwdata_i[1:0];
                setup_err <= 1'b0;
              end
            end
          end
          `PEC_OFF_IRQ_MASK: irq_mask <= pwdata_i[`PEC_IRQ_W-1:0];
          `PEC_OFF_SEL: sel <= pwdata_i[`PEC_SEL_W*NCH-1:0];
          default: begin
          end
        endcase
      end
      irq_stat <= next_irq_stat;
      irq_o <= |(next_irq_stat & irq_mask);
      ovf_prev <= ovf;
      window_open_o <= win_open;
      // window breaks feed the counters only, never the halt
      cpu_halt_o <= brk_halt_req_i &
        !(is_win_mode && (brk1_i || brk2_i)); // RULE4
    end
  end
endmodule

// ---- common/pec_map.vh ----
/*
 * register offsets, field positions, event class codes and reset values
 * of the performance event counter block. definitions only.
 */
// How it works
// (RULE1) in whole-run mode counting starts when the program runs and stops at any break.
// (RULE2) in mode one-to-two the window opens at break condition one and closes at two.
// (RULE3) in mode two-to-one the window opens at break condition two and closes at one.
// (RULE4) window break conditions never halt the program; a halt request is masked.
// (RULE5) four channels count at the same time, each programmed on its own.
// (RULE6) each channel is disabled or selects one event class.
// (RULE7) unit-specific classes count only when that unit is present.
// (RULE8) a taken branch adds two to a branch counter.
// (RULE9) a cacheable-area access counts as cacheable even if not cached.
// (RULE10) counters advance only while the cpu clock runs (clock enable).
// (RULE11) each channel result is a 32-bit readable value.
// (RULE12) overflow past the maximum is detected and shown.
// (RULE13) an initialize request clears all results.
// (RULE14) the debugger programs start and end conditions before running.
// (RULE15) a window mode with no channel enabled is refused as an error.
// (RULE16) the debugger does not single-step in a window mode.
// (RULE17) overflow stays set until initialize and the counter saturates.
`ifndef PEC_MAP_VH
`define PEC_MAP_VH

`define PEC_OFF_CTRL 12'h000
`define PEC_OFF_STAT 12'h004
`define PEC_OFF_IRQ_STAT 12'h008
`define PEC_OFF_IRQ_MASK 12'h00c
`define PEC_OFF_SEL 12'h010
`define PEC_OFF_CNT0 12'h020

// ctrl fields
`define PEC_CTRL_MODE_LO 0
`define PEC_CTRL_MODE_HI 1
`define PEC_CTRL_INIT 4
`define PEC_CTRL_RESET 32'h0000_0000

`define PEC_MODE_RUN 2'h0
`define PEC_MODE_1TO2 2'h1
`define PEC_MODE_2TO1 2'h2

// status fields
`define PEC_STAT_WIN 0
`define PEC_STAT_ERR 1
`define PEC_STAT_OVF_LO 4

// irq bits: overflow per channel, then window close, then setup error
`define PEC_IRQ_CLOSE 4
`define PEC_IRQ_ERR 5
`define PEC_IRQ_W 6

// event classes, 5 bits per channel in sel register
`define PEC_SEL_W 5
`define PEC_EV_OFF 5'h00
`define PEC_EV_TIME 5'h01
`define PEC_EV_STATES 5'h02
`define PEC_EV_BRANCH 5'h03
`define PEC_EV_INSN 5'h04
`define PEC_EV_DSP 5'h05
`define PEC_EV_EXC 5'h06
`define PEC_EV_INT 5'h07
`define PEC_EV_ICMISS 5'h08
`define PEC_EV_DCMISS 5'h09
`define PEC_EV_STALL 5'h0a
`define PEC_EV_DTLB 5'h0b
`define PEC_EV_ITLB 5'h0c
`define PEC_EV_XYSTALL 5'h0d
`define PEC_EV_USTALL 5'h0e
`define PEC_EV_CC_CYC 5'h0f
`define PEC_EV_NC_CYC 5'h10
`define PEC_EV_CC_CNT 5'h11
`define PEC_EV_NC_CNT 5'h12

`endif

// ---- rtl/pec_window.v ----
/*
 * measurement window control: opens and closes the counting window
 * from run state and the two break conditions.
 * assumes run and break inputs are synchronous single-cycle levels.
 */
`timescale 1ns/1ps
`include "pec_map.vh"
module pec_window (
  input wire sys_clk_i,
  input wire reset_n_i,
  input wire ce_i,
  input wire [1:0] mode_i,
  input wire arm_ok_i,
  input wire run_start_i,
  input wire any_break_i,
  input wire brk1_i,
  input wire brk2_i,
  output reg open_o,
  output wire close_o
);
  wire is_run;
  wire open_ev;
  wire close_ev;
  assign is_run = (mode_i == `PEC_MODE_RUN);
  assign open_ev = arm_ok_i & (is_run ? run_start_i : // RULE1
    (mode_i == `PEC_MODE_1TO2) ? brk1_i : // RULE2
    (mode_i == `PEC_MODE_2TO1) ? brk2_i : 1'b0); // RULE3
  assign close_ev = is_run ? any_break_i :
    (mode_i == `PEC_MODE_1TO2) ? brk2_i :
    (mode_i == `PEC_MODE_2TO1) ? brk1_i : 1'b0;
  assign close_o = open_o & close_ev & ce_i;

  always @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      open_o <= 1'b0;
    end else if (ce_i) begin // RULE10
      if (open_o && close_ev) begin
        open_o <= 1'b0;
      end else if (!open_o && open_ev) begin
        open_o <= 1'b1;
      end
    end
  end
endmodule

// ---- rtl/pec_counter.v ----
/*
 * one 32-bit event counter channel with saturating overflow flag.
 * assumes event inputs are one-cycle-per-event synchronous strobes.
 */
`timescale 1ns/1ps
`include "pec_map.vh"
module pec_counter #(
  parameter WIDTH = 32,
  parameter HAS_DSP = 1,
  parameter HAS_MMU = 1,
  parameter HAS_XY = 1,
  parameter HAS_U = 1
) (
  input wire sys_clk_i,
  input wire reset_n_i,
  input wire ce_i,
  input wire count_en_i,
  input wire init_i,
  input wire [4:0] sel_i,
  input wire [18:0] ev_i,
  output reg [WIDTH-1:0] count_o,
  output reg ovf_o
);
  reg [1:0] inc;
  reg present;
  wire [WIDTH:0] sum;

  always @* begin
    present = 1'b1;
    case (sel_i)
      `PEC_EV_DSP: present = (HAS_DSP != 0); // RULE7
      `PEC_EV_DTLB, `PEC_EV_ITLB: present = (HAS_MMU != 0);
      `PEC_EV_XYSTALL: present = (HAS_XY != 0);
      `PEC_EV_USTALL: present = (HAS_U != 0);
      default: present = 1'b1;
    endcase
    inc = 2'h0;
    if (sel_i != `PEC_EV_OFF && sel_i <= `PEC_EV_NC_CNT && present &&
        ev_i[sel_i]) begin // RULE6
      if (sel_i == `PEC_EV_BRANCH) begin
        inc = 2'h2; // RULE8
      end else begin
        inc = 2'h1;
      end
    end
  end

  assign sum = {1'b0, count_o} + {{(WIDTH-1){1'b0}}, inc};

  always @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      count_o <= {WIDTH{1'b0}};
      ovf_o <= 1'b0;
    end else if (ce_i) begin // RULE10
      if (init_i) begin
        count_o <= {WIDTH{1'b0}}; // RULE13
        ovf_o <= 1'b0;
      end else if (count_en_i && !ovf_o) begin
        if (sum[WIDTH]) begin
          count_o <= {WIDTH{1'b1}}; // RULE17
          ovf_o <= 1'b1; // RULE12
        end else begin
          count_o <= sum[WIDTH-1:0]; // RULE11
        end
      end
    end
  end
endmodule

// ---- testbench/pec_chk_assertions.sv ----
/* pin-level assertions for pec_top.
   assumes it is bound to pec_top from the bench top file. */
`timescale 1ns/1ps
module pec_chk (
  input wire sys_clk_i,
  input wire reset_n_i,
  input wire ce_i,
  input wire psel_i,
  input wire penable_i,
  input wire run_start_i,
  input wire any_break_i,
  input wire brk1_i,
  input wire brk2_i,
  input wire brk_halt_req_i,
  input wire [31:0] prdata_o,
  input wire pready_o,
  input wire pslverr_o,
  input wire cpu_halt_o,
  input wire window_open_o,
  input wire irq_o
);
  wire opn = run_start_i | brk1_i | brk2_i;
  wire cls = any_break_i | brk1_i | brk2_i;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);
  ready_after_setup_a: assert property (
    ce_i && psel_i && !penable_i |=> pready_o) else $error("ready missing");
  ready_one_cycle_a: assert property (
    pready_o && ce_i |=> !pready_o) else $error("ready too long");
  ready_cause_a: assert property (
    $rose(pready_o) |-> $past(psel_i && !penable_i))
    else $error("ready without setup");
  err_read_zero_a: assert property (
    pslverr_o |-> pready_o && prdata_o == 32'h0) else $error("bad error");
  halt_follow_a: assert property (
    ce_i && !brk1_i && !brk2_i |=> cpu_halt_o == $past(brk_halt_req_i))
    else $error("halt wrong");
  sleep_freeze_a: assert property (
    !ce_i |=> $stable(window_open_o) && $stable(irq_o) && $stable(prdata_o))
    else $error("moved in sleep");
  open_cause_a: assert property (
    $rose(window_open_o) |-> $past(opn, 2) || $past(opn, 3))
    else $error("open without event");
  close_cause_a: assert property (
    $fell(window_open_o) |-> $past(cls, 2) || $past(cls, 3))
    else $error("close without event");
  irq_hold_a: assert property (
    irq_o && !psel_i |=> irq_o) else $error("irq dropped");
  cover property (pready_o && pslverr_o);
  cover property ($rose(window_open_o));
  cover property ($rose(irq_o));
endmodule

// ---- testbench/pec_emu.sv ----
/* apb master standing in for the debug emulator.
   assumes xfer is called from one process in the clk_i domain. */
`timescale 1ns/1ps
module pec_emu (
  input wire clk_i,
  input wire pready_i,
  input wire pslverr_i,
  input wire [31:0] prdata_i,
  output logic psel_o = 0,
  output logic penable_o = 0,
  output logic pwrite_o = 0,
  output logic [11:0] paddr_o = 0,
  output logic [31:0] pwdata_o = 0
);
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
            output logic [31:0] r, output logic e);
    int n;
    @(posedge clk_i);
    psel_o <= 1;
    pwrite_o <= w;
    paddr_o <= a;
    pwdata_o <= d;
    @(posedge clk_i);
    penable_o <= 1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready_i !== 1'b1 && n < 20);
    r = pready_i === 1'b1 ? prdata_i : 'x;
    e = pslverr_i;
    psel_o <= 0;
    penable_o <= 0;
    // released data flips so stale values never look fresh
    pwdata_o <= ~d;
  endtask
endmodule

// ---- testbench/test_performance_event_counters.sv ----
/* self-checking bench for pec_top with the dsp unit left out.
   assumes pec_map.vh on the include path. */
`timescale 1ns/1ps
`include "pec_map.vh"
module test_performance_event_counters;
  logic clk, rst_n, ce, run, anyb, b1, b2, hreq, cc;
  logic [14:0] ev;
  logic [3:0] p;
  logic [31:0] r;
  logic e;
  wire psel, pen, pwr, rdy, err, halt, wopen, irq;
  wire [11:0] addr;
  wire [31:0] wdata, rdata;
  int bad_count = 0;
  int comparisons = 0;
  int cyc = 0;
  int i, c;
  // code, strobes, cacheable area, expected count
  logic [52:0] rows [8] = '{
    {5'h03, 15'h0002, 1'b0, 32'd6},
    {5'h02, 15'h0001, 1'b0, 32'd3},
    {5'h04, 15'h0004, 1'b0, 32'd3},
    {5'h05, 15'h0008, 1'b0, 32'd0},
    {5'h0f, 15'h2000, 1'b1, 32'd3},
    {5'h10, 15'h2000, 1'b1, 32'd0},
    {5'h12, 15'h4000, 1'b0, 32'd3},
    {5'h00, 15'h7fff, 1'b0, 32'd0}};
  pec_emu pec_emu_i (.clk_i(clk), .pready_i(rdy), .pslverr_i(err),
    .prdata_i(rdata), .psel_o(psel), .penable_o(pen), .pwrite_o(pwr),
    .paddr_o(addr), .pwdata_o(wdata));
  pec_top #(.HAS_DSP(0)) pec_top_i (.sys_clk_i(clk), .reset_n_i(rst_n),
    .ce_i(ce), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
    .paddr_i(addr), .pwdata_i(wdata), .prdata_o(rdata), .pready_o(rdy),
    .pslverr_o(err), .run_start_i(run), .any_break_i(anyb), .brk1_i(b1),
    .brk2_i(b2), .brk_halt_req_i(hreq), .tick_i(1'b0), .state_i(ev[0]),
    .branch_i(ev[1]), .insn_i(ev[2]), .dsp_insn_i(ev[3]), .exc_i(ev[4]),
    .int_i(ev[5]), .icache_miss_i(ev[6]), .dcache_miss_i(ev[7]),
    .stall_i(ev[8]), .dtlb_miss_i(ev[9]), .itlb_miss_i(ev[10]),
    .xy_stall_i(ev[11]), .u_stall_i(ev[12]), .acc_cyc_i(ev[13]),
    .acc_start_i(ev[14]), .area_cacheable_i(cc), .cpu_halt_o(halt),
    .window_open_o(wopen), .irq_o(irq));
  task wrap_up;
    if (bad_count == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    comparisons++;
    if (g !== x) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, x, g);
    end
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    pec_emu_i.xfer(1'b1, a, d, r, e);
  endtask
  task rd(input logic [11:0] a, input logic [31:0] x);
    pec_emu_i.xfer(1'b0, a, 32'h0, r, e);
    chk("prdata", x, r);
    chk("pslverr", {31'h0, a == 12'h100}, {31'h0, e});
  endtask
  task go(input logic [3:0] v);
    @(posedge clk);
    {run, anyb, b1, b2} <= v;
    @(posedge clk);
    {run, anyb, b1, b2} <= 4'h0;
  endtask
  task evs(input logic [14:0] m);
    repeat (3) begin
      @(posedge clk);
      ev <= m;
    end
    @(posedge clk);
    ev <= 15'h0;
  endtask
  initial begin
    clk = 0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc > 5000) begin
      bad_count++;
      wrap_up;
    end
  end
  initial begin
    rst_n = 0;
    ce = 1;
    {run, anyb, b1, b2} = 4'h0;
    hreq = 0;
    cc = 0;
    ev = 15'h0;
    repeat (6) @(posedge clk);
    rst_n <= 1;
    rd(`PEC_OFF_CTRL, `PEC_CTRL_RESET);
    rd(`PEC_OFF_STAT, 32'h0);
    foreach (rows[i]) begin
      wr(`PEC_OFF_SEL, {12'h0, {4{rows[i][52:48]}}});
      wr(`PEC_OFF_CTRL, 32'h10);
      cc <= rows[i][32];
      evs(rows[i][47:33]);
      go(4'b1000);
      evs(rows[i][47:33]);
      go(4'b0100);
      for (c = 0; c < 4; c++)
        rd(12'(`PEC_OFF_CNT0 + 4 * c), rows[i][31:0]);
    end
    wr(`PEC_OFF_SEL, {27'h0, `PEC_EV_INSN});
    for (i = 1; i < 3; i++) begin
      wr(`PEC_OFF_CTRL, 32'h10 | i);
      p = i == 1 ? 4'b0010 : 4'b0001;
      go(p ^ 4'b0011);
      evs(15'h4);
      hreq <= 1;
      go(p);
      hreq <= 0;
      #1 chk("cpu_halt", 32'h0, {31'h0, halt});
      evs(15'h4);
      go(p ^ 4'b0011);
      evs(15'h4);
      rd(`PEC_OFF_CNT0, 32'd3);
    end
    wr(`PEC_OFF_CTRL, 32'h10);
    go(4'b1000);
    repeat (3) @(posedge clk);
    ce <= 0;
    evs(15'h4);
    ce <= 1;
    evs(15'h4);
    go(4'b0100);
    rd(`PEC_OFF_CNT0, 32'd3);
    wr(`PEC_OFF_SEL, 32'h0);
    wr(`PEC_OFF_IRQ_MASK, 32'h20);
    wr(`PEC_OFF_CTRL, 32'h1);
    rd(`PEC_OFF_CTRL, 32'h0);
    rd(`PEC_OFF_STAT, 32'h2);
    chk("irq", 32'h1, {31'h0, irq});
    wr(`PEC_OFF_IRQ_STAT, 32'h20);
    @(posedge clk);
    #1 chk("irq", 32'h0, {31'h0, irq});
    rd(12'h100, 32'h0);
    wrap_up;
  end
endmodule
bind pec_top pec_chk pec_chk_i (.*);
